// ---- rtl/sem_pkg.sv ----
package sem_pkg;
    // register offsets
    localparam logic [11:0] SEM_ADDR_LINK_PAGE = 12'h300;
    localparam logic [11:0] SEM_ADDR_PULSE     = 12'h312;
    localparam logic [11:0] SEM_ADDR_ERR_SEL   = 12'h46b;
    localparam logic [11:0] SEM_ADDR_DISP      = 12'h46d;
    localparam logic [11:0] SEM_ADDR_MISS      = 12'h46e;
    localparam logic [11:0] SEM_ADDR_CTRL      = 12'h46f;
    localparam logic [11:0] SEM_ADDR_ILAS_STAT = 12'h473;
    localparam logic [11:0] SEM_ADDR_TEST      = 12'h477;
    localparam logic [11:0] SEM_ADDR_IRQ       = 12'h47a;
    localparam logic [11:0] SEM_ADDR_RESYNC    = 12'h47b;
    localparam logic [11:0] SEM_ADDR_LIMIT     = 12'h47c;
    localparam logic [11:0] SEM_ADDR_LANE_EN   = 12'h47d;
    // field positions
    localparam int SEM_PAGE_BIT      = 2;
    localparam int SEM_PULSE_LSB     = 4;
    localparam int SEM_SEL_LANE_LSB  = 4;
    localparam int SEM_ILAS_TEST_BIT = 7;
    localparam int SEM_THR_MASK_BIT  = 3;
    localparam int SEM_CTL_IRQ_CLR   = 7;
    localparam int SEM_CTL_INHIBIT   = 6;
    localparam int SEM_CTL_CLEAR     = 5;
    localparam int SEM_TYPE_TOP_BIT  = 7;
    // reset values
    localparam logic [7:0] SEM_LIMIT_RST   = 8'hff;
    localparam logic [7:0] SEM_LANE_EN_RST = 8'hff;
    // timing and counts
    localparam logic [2:0] SEM_CGS_NEEDED     = 3'h4;
    localparam logic [2:0] SEM_REINIT_DISP    = 3'h4;
    localparam int         SEM_SYNC_PULSE_FR  = 2;
    localparam int         SEM_RESYNC_FRAMES  = 5;
    localparam int         SEM_RESYNC_OCTETS  = 9;
    localparam int         SEM_TYPES          = 3;

    typedef enum logic [1:0] {
        SEM_CNT_DISP = 2'h0,
        SEM_CNT_MISS = 2'h1,
        SEM_CNT_CTRL = 2'h2,
        SEM_CNT_NONE = 2'h3
    } sem_pick_t;

    typedef enum logic [1:0] {
        SEM_ST_IDLE,
        SEM_ST_CGS,
        SEM_ST_RUN,
        SEM_ST_RESYNC
    } sem_state_t;
endpackage : sem_pkg

// ---- rtl/sem_err_counter.sv ----
`timescale 1ns/100ps
module sem_err_counter #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // control
    input  wire logic         err,
    input  wire logic         clear,
    input  wire logic         inhibit,
    input  wire logic         no_sat,
    input  wire logic [W-1:0] limit,
    // state
    output logic      [W-1:0] count_q,
    output logic              reached_q
);
    logic [W-1:0] count_d;
    logic         reached_d;

    always_comb begin
        count_d   = count_q;
        reached_d = reached_q;
        if (clear) begin
            count_d   = '0;
            reached_d = 1'b0;
        end else begin
            if (err && !inhibit) begin
                if (no_sat || count_q < limit) begin
                    count_d = count_q + 1'b1; // R18
                end
            end
            if (count_d >= limit) begin
                reached_d = 1'b1; // R11
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_q   <= '0;
            reached_q <= 1'b0;
        end else begin
            count_q   <= count_d;
            reached_q <= reached_d;
        end
    end

    sat_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
        (!no_sat && count_q == limit && err && !inhibit && !clear) |=> $stable(count_q))
        else $error("count moved past limit");
    wrap_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R18
        (no_sat && err && !inhibit && !clear) |=> count_q == $past(count_q) + 1'b1)
        else $error("unsaturated count did not step");
    inhibit_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
        (inhibit && !clear) |=> $stable(count_q))
        else $error("inhibited count moved");
endmodule : sem_err_counter

// ---- rtl/sem_monitor.sv ----
`timescale 1ns/100ps
// Contract
// R1 - ILAS test bit set before link enable accepts CGS then repeated ILAS.
// R2 - release sync request after four K28.5 on every enabled lane.
// R3 - transmitter repeats ILAS once sync request is released.
// R4 - page bit routes lane status and per-lane error access to link 0 or 1.
// R5 - with link 1 selected, link lane x means logical lane x plus four.
// R6 - detect disparity, table miss and control char errors; optionally resync.
// R7 - disparity counter counts every bad-disparity character, table entry or not.
// R8 - lane and counter picked in one register, count read back there.
// R9 - counter pick 0 disparity, 1 table miss, 2 control character.
// R10 - counts saturate at the single shared error limit.
// R11 - one status register per error type shows lanes at the limit.
// R12 - status writes on lane bits 2:0: clear irq, inhibit count, clear count.
// R13 - status register reads give over-limit state, not the written value.
// R14 - any error pulses the sync request output.
// R15 - pulse length field 0,1,2 gives a two-frame pulse; resets to 0.
// R16 - irq bits 7:5 enable over-limit events, read back as event status.
// R17 - four bad-disparity characters reinitialise; resync 5 frames plus 9 octets.
// R18 - threshold mask enable stops saturation for unmasked types; the code stops it for the resync-masked types instead.
// R19 - resync-masked type at the limit on any lane drops sync request.
// R20 - reinitialisation clears all counters; irq flags stay until cleared.
// R21 - software reads per-lane ILAS pass status during repeated ILAS test.
// R22 - ILAS status bit x is high when link lane x passed ILAS.
// R23 - counter pick 3 reads zero and touches no counter.
module sem_monitor
    import sem_pkg::*;
#(
    parameter int LANES            = 8,
    parameter int OCTETS_PER_FRAME = 1
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // register port
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [11:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // link lanes
    input  wire logic             link_enable,
    input  wire logic [LANES-1:0] lane_k28_seen,
    input  wire logic [LANES-1:0] lane_ilas_pass,
    input  wire logic [LANES-1:0] lane_disp_err,
    input  wire logic [LANES-1:0] lane_table_miss,
    input  wire logic [LANES-1:0] lane_ctrl_err,
    // link control
    output logic                  sync_request_out_n,
    output logic                  link_reinit
);
    import sem_pkg::*;

    if (LANES != 8 || OCTETS_PER_FRAME < 1 || OCTETS_PER_FRAME > 16) begin : g_bad_params
        $error("sem_monitor: unsupported LANES or OCTETS_PER_FRAME");
    end

    function automatic logic [5:0] frames_to_cycles(input int frames, input logic [1:0] len);
        int fpc;
        fpc = (len == 2'h0) ? 4 : (len == 2'h1) ? 2 : 1;
        return 6'((frames + fpc - 1) / fpc);
    endfunction : frames_to_cycles

    function automatic logic [2:0] lane_map(input logic [2:0] idx, input logic page);
        return idx + {page, 2'h0}; // R5
    endfunction : lane_map

    localparam int RESYNC_FR = SEM_RESYNC_FRAMES
                             + (SEM_RESYNC_OCTETS + OCTETS_PER_FRAME - 1) / OCTETS_PER_FRAME;

    // register file
    logic             page_q, page_d;
    logic [1:0]       pulse_len_q, pulse_len_d;
    logic [2:0]       lane_pick_q, lane_pick_d;
    sem_pick_t        counter_pick_q, counter_pick_d;
    logic             ilas_test_q, ilas_test_d;
    logic             thr_mask_q, thr_mask_d;
    logic [2:0]       irq_en_q, irq_en_d;
    logic [2:0]       resync_mask_q, resync_mask_d;
    logic [7:0]       error_limit_q, error_limit_d;
    logic [LANES-1:0] lane_en_q, lane_en_d;
    logic [LANES-1:0] inhibit_q [SEM_TYPES];
    logic [LANES-1:0] inhibit_d [SEM_TYPES];
    logic [LANES-1:0] irq_q [SEM_TYPES];
    logic [LANES-1:0] irq_d [SEM_TYPES];
    logic [7:0]       rdata_d;

    // link state
    sem_state_t       st_q, st_d;
    logic [2:0]       cgs_cnt_q [LANES];
    logic [2:0]       cgs_cnt_d [LANES];
    logic [2:0]       disp_tot_q [LANES];
    logic [2:0]       disp_tot_d [LANES];
    logic [5:0]       timer_q, timer_d;
    logic [5:0]       pulse_q, pulse_d;
    logic             sync_n_d;

    // counter fabric
    logic [LANES-1:0] err_bus [SEM_TYPES];
    logic [LANES-1:0] cnt_clr [SEM_TYPES];
    logic [LANES-1:0] reached [SEM_TYPES];
    logic [7:0]       count_w [SEM_TYPES][LANES];
    logic             counting;
    logic             reinit_w;
    logic             cgs_all_w;
    logic             err_any;
    logic [2:0]       type_reached;
    logic [2:0]       sel_log;
    logic [2:0]       wr_type;
    logic             wr_is_type;

    assign counting = (st_q == SEM_ST_RUN);
    assign sel_log  = lane_map(lane_pick_q, page_q);
    assign err_bus[0] = lane_disp_err & lane_en_q & {LANES{counting}}; // R7
    assign err_bus[1] = lane_table_miss & lane_en_q & {LANES{counting}}; // R6
    assign err_bus[2] = lane_ctrl_err & lane_en_q & {LANES{counting && !ilas_test_q}}; // R1
    assign err_any    = |(err_bus[0] | err_bus[1] | err_bus[2]);
    assign wr_is_type = reg_wr && (reg_addr == SEM_ADDR_DISP || reg_addr == SEM_ADDR_MISS
                                   || reg_addr == SEM_ADDR_CTRL);
    assign wr_type[0] = reg_wr && reg_addr == SEM_ADDR_DISP;
    assign wr_type[1] = reg_wr && reg_addr == SEM_ADDR_MISS;
    assign wr_type[2] = reg_wr && reg_addr == SEM_ADDR_CTRL;

    genvar gt, gl;
    generate
        for (gt = 0; gt < SEM_TYPES; gt++) begin : g_type
            // mask bits run disparity high to control low, types run the other way
            assign type_reached[SEM_TYPES-1-gt] = |reached[gt]; // R19
            for (gl = 0; gl < LANES; gl++) begin : g_lane
                assign cnt_clr[gt][gl] = reinit_w // R20
                    || (wr_type[gt] && reg_wdata[SEM_CTL_CLEAR]
                        && lane_map(reg_wdata[2:0], page_q) == 3'(gl)); // R12
                sem_err_counter #(.W(8)) u_cnt (
                    .clk_sys   (clk_sys),
                    .sys_rst   (sys_rst),
                    .err       (err_bus[gt][gl]),
                    .clear     (cnt_clr[gt][gl]),
                    .inhibit   (inhibit_q[gt][gl]),
                    .no_sat    (thr_mask_q && resync_mask_q[SEM_TYPES-1-gt]), // R18
                    .limit     (error_limit_q), // R10
                    .count_q   (count_w[gt][gl]),
                    .reached_q (reached[gt][gl])
                );
            end
        end
    endgenerate

    // register group
    always_comb begin
        page_d         = page_q;
        pulse_len_d    = pulse_len_q;
        lane_pick_d    = lane_pick_q;
        counter_pick_d = counter_pick_q;
        ilas_test_d    = ilas_test_q;
        thr_mask_d     = thr_mask_q;
        irq_en_d       = irq_en_q;
        resync_mask_d  = resync_mask_q;
        error_limit_d  = error_limit_q;
        lane_en_d      = lane_en_q;
        rdata_d        = reg_rdata;
        for (int t = 0; t < SEM_TYPES; t++) begin
            inhibit_d[t] = inhibit_q[t];
            irq_d[t]     = irq_q[t];
            if (wr_type[t]) begin
                for (int l = 0; l < LANES; l++) begin
                    if (lane_map(reg_wdata[2:0], page_q) == 3'(l)) begin
                        inhibit_d[t][l] = reg_wdata[SEM_CTL_INHIBIT]; // R12
                        if (reg_wdata[SEM_CTL_IRQ_CLR]) begin
                            irq_d[t][l] = 1'b0; // R12
                        end
                    end
                end
            end
            irq_d[t] = irq_d[t] | reached[t]; // R20
        end
        if (reg_wr && !wr_is_type) begin
            unique case (reg_addr)
                SEM_ADDR_LINK_PAGE: page_d = reg_wdata[SEM_PAGE_BIT]; // R4
                SEM_ADDR_PULSE:     pulse_len_d = reg_wdata[SEM_PULSE_LSB +: 2]; // R15
                SEM_ADDR_ERR_SEL: begin
                    lane_pick_d    = reg_wdata[SEM_SEL_LANE_LSB +: 3]; // R8
                    counter_pick_d = sem_pick_t'(reg_wdata[1:0]);
                end
                SEM_ADDR_TEST: begin
                    ilas_test_d = reg_wdata[SEM_ILAS_TEST_BIT]; // R1
                    thr_mask_d  = reg_wdata[SEM_THR_MASK_BIT];
                end
                SEM_ADDR_IRQ:     irq_en_d = reg_wdata[SEM_TYPE_TOP_BIT -: 3]; // R16
                SEM_ADDR_RESYNC:  resync_mask_d = reg_wdata[SEM_TYPE_TOP_BIT -: 3];
                SEM_ADDR_LIMIT:   error_limit_d = reg_wdata;
                SEM_ADDR_LANE_EN: lane_en_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                SEM_ADDR_LINK_PAGE: rdata_d = 8'(page_q) << SEM_PAGE_BIT;
                SEM_ADDR_PULSE:     rdata_d = 8'(pulse_len_q) << SEM_PULSE_LSB;
                SEM_ADDR_ERR_SEL: begin
                    unique case (counter_pick_q) // R9
                        SEM_CNT_DISP: rdata_d = count_w[0][sel_log];
                        SEM_CNT_MISS: rdata_d = count_w[1][sel_log];
                        SEM_CNT_CTRL: rdata_d = count_w[2][sel_log];
                        SEM_CNT_NONE: rdata_d = 8'h00; // R23
                    endcase
                end
                SEM_ADDR_DISP: rdata_d = reached[0] >> (page_q ? 4 : 0); // R13
                SEM_ADDR_MISS: rdata_d = reached[1] >> (page_q ? 4 : 0); // R11
                SEM_ADDR_CTRL: rdata_d = reached[2] >> (page_q ? 4 : 0); // R11
                SEM_ADDR_ILAS_STAT:
                    rdata_d = (lane_ilas_pass & lane_en_q) >> (page_q ? 4 : 0); // R21 R22
                SEM_ADDR_TEST:
                    rdata_d = (8'(ilas_test_q) << SEM_ILAS_TEST_BIT)
                            | (8'(thr_mask_q) << SEM_THR_MASK_BIT);
                SEM_ADDR_IRQ: rdata_d = {irq_en_q & {|irq_q[0], |irq_q[1], |irq_q[2]},
                                         5'h00}; // R16
                SEM_ADDR_RESYNC:  rdata_d = {resync_mask_q, 5'h00};
                SEM_ADDR_LIMIT:   rdata_d = error_limit_q;
                SEM_ADDR_LANE_EN: rdata_d = lane_en_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            page_q         <= 1'b0;
            pulse_len_q    <= 2'h0;
            lane_pick_q    <= 3'h0;
            counter_pick_q <= SEM_CNT_DISP;
            ilas_test_q    <= 1'b0;
            thr_mask_q     <= 1'b0;
            irq_en_q       <= 3'h0;
            resync_mask_q  <= 3'h0;
            error_limit_q  <= SEM_LIMIT_RST;
            lane_en_q      <= SEM_LANE_EN_RST;
            reg_rdata      <= 8'h00;
            for (int t = 0; t < SEM_TYPES; t++) begin
                inhibit_q[t] <= '0;
                irq_q[t]     <= '0;
            end
        end else begin
            page_q         <= page_d;
            pulse_len_q    <= pulse_len_d;
            lane_pick_q    <= lane_pick_d;
            counter_pick_q <= counter_pick_d;
            ilas_test_q    <= ilas_test_d;
            thr_mask_q     <= thr_mask_d;
            irq_en_q       <= irq_en_d;
            resync_mask_q  <= resync_mask_d;
            error_limit_q  <= error_limit_d;
            lane_en_q      <= lane_en_d;
            reg_rdata      <= rdata_d;
            for (int t = 0; t < SEM_TYPES; t++) begin
                inhibit_q[t] <= inhibit_d[t];
                irq_q[t]     <= irq_d[t];
            end
        end
    end

    // link group
    always_comb begin
        cgs_all_w = |lane_en_q;
        reinit_w  = counting && !ilas_test_q && |(resync_mask_q & type_reached); // R19
        for (int l = 0; l < LANES; l++) begin
            cgs_cnt_d[l]  = cgs_cnt_q[l];
            disp_tot_d[l] = disp_tot_q[l];
            if (st_q == SEM_ST_CGS && lane_k28_seen[l] && cgs_cnt_q[l] < SEM_CGS_NEEDED) begin
                cgs_cnt_d[l] = cgs_cnt_q[l] + 3'h1;
            end
            if (lane_en_q[l] && cgs_cnt_q[l] < SEM_CGS_NEEDED) begin
                cgs_all_w = 1'b0; // R2
            end
            if (err_bus[0][l] && !ilas_test_q) begin
                disp_tot_d[l] = disp_tot_q[l] + 3'h1;
                if (disp_tot_d[l] == SEM_REINIT_DISP) begin
                    reinit_w = 1'b1; // R17
                end
            end
        end
        st_d    = st_q;
        timer_d = (timer_q != 6'h00) ? timer_q - 6'h01 : 6'h00;
        pulse_d = (pulse_q != 6'h00) ? pulse_q - 6'h01 : 6'h00;
        unique case (st_q)
            SEM_ST_IDLE: if (link_enable) st_d = SEM_ST_CGS;
            SEM_ST_CGS:  if (cgs_all_w) st_d = SEM_ST_RUN; // R2
            SEM_ST_RUN: begin
                if (reinit_w) begin
                    st_d    = SEM_ST_RESYNC;
                    timer_d = frames_to_cycles(RESYNC_FR, pulse_len_q); // R17
                end else if (err_any && !ilas_test_q) begin
                    pulse_d = frames_to_cycles(SEM_SYNC_PULSE_FR, pulse_len_q); // R14
                end
            end
            SEM_ST_RESYNC: if (timer_q <= 6'h01) st_d = SEM_ST_CGS;
        endcase
        if (!link_enable) begin
            st_d = SEM_ST_IDLE;
        end
        if (st_d != SEM_ST_RUN) begin
            pulse_d = 6'h00;
            for (int l = 0; l < LANES; l++) begin
                disp_tot_d[l] = 3'h0;
                if (st_d != SEM_ST_CGS) cgs_cnt_d[l] = 3'h0;
            end
        end
        sync_n_d = (st_d == SEM_ST_RUN) && (pulse_d == 6'h00);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q               <= SEM_ST_IDLE;
            timer_q            <= 6'h00;
            pulse_q            <= 6'h00;
            sync_request_out_n <= 1'b0;
            link_reinit        <= 1'b0;
            for (int l = 0; l < LANES; l++) begin
                cgs_cnt_q[l]  <= 3'h0;
                disp_tot_q[l] <= 3'h0;
            end
        end else begin
            st_q               <= st_d;
            timer_q            <= timer_d;
            pulse_q            <= pulse_d;
            sync_request_out_n <= sync_n_d;
            link_reinit        <= reinit_w;
            cgs_cnt_q          <= cgs_cnt_d;
            disp_tot_q         <= disp_tot_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    idle_sync_low_a: assert property ( // R2
        st_q == SEM_ST_IDLE |-> !sync_request_out_n)
        else $error("sync released while idle");
    cgs_release_a: assert property ( // R2
        (st_q == SEM_ST_CGS && cgs_all_w && link_enable) |=> sync_request_out_n)
        else $error("sync not released after cgs");
    err_pulse_a: assert property ( // R14
        (counting && err_any && !ilas_test_q && !reinit_w && link_enable)
        |=> !sync_request_out_n)
        else $error("error did not pulse sync");
    reinit_resync_a: assert property ( // R17
        (reinit_w && link_enable) |=> link_reinit && st_q == SEM_ST_RESYNC
        && !sync_request_out_n)
        else $error("reinit did not start resync");
    reinit_clear_a: assert property ( // R20
        reinit_w |=> !type_reached[0] && !type_reached[1] && !type_reached[2])
        else $error("counts survived reinit");
    irq_hold_a: assert property ( // R20
        (irq_q[0][0] && !(wr_type[0] && reg_wdata[SEM_CTL_IRQ_CLR])) |=> irq_q[0][0])
        else $error("irq dropped without clear");
    pick_none_a: assert property ( // R23
        (reg_rd && reg_addr == SEM_ADDR_ERR_SEL && counter_pick_q == SEM_CNT_NONE)
        |=> reg_rdata == 8'h00)
        else $error("unassigned pick read nonzero");
    mask_drop_a: assert property ( // R19
        (counting && !ilas_test_q && link_enable && |(resync_mask_q & type_reached))
        |=> !sync_request_out_n)
        else $error("masked limit kept sync high");

    run_reached_c: cover property (st_q == SEM_ST_CGS ##1 st_q == SEM_ST_RUN);
    reinit_seen_c: cover property (link_reinit ##[1:40] st_q == SEM_ST_RUN);
    irq_pending_c: cover property (|irq_en_q && |irq_q[0]);
endmodule : sem_monitor

// ---- testbench/sem_tx_model.sv ----
`timescale 1ns/100ps
// far transmitter: commas while sync is requested, alignment after release
module sem_tx_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // link
    input  wire logic       sync_request_out_n,
    output logic      [7:0] lane_k28_seen,
    output logic      [7:0] lane_ilas_pass
);
    logic [7:0] k28_d;
    logic [7:0] pass_d;
    always_comb begin
        k28_d  = sync_request_out_n ? 8'h00 : 8'hff;
        pass_d = sync_request_out_n ? 8'hff : 8'h00;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lane_k28_seen  <= 8'h00;
            lane_ilas_pass <= 8'h00;
        end else begin
            lane_k28_seen  <= k28_d;
            lane_ilas_pass <= pass_d;
        end
    end
endmodule : sem_tx_model

// ---- testbench/sem_monitor_tb.sv ----
`timescale 1ns/100ps
module sem_monitor_tb;
    import sem_pkg::*;
    logic        clk_sys     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [11:0] reg_addr    = 12'h000;
    logic [7:0]  reg_wdata   = 8'h00;
    logic [7:0]  reg_rdata;
    logic        link_enable = 1'b0;
    logic [7:0]  k28;
    logic [7:0]  pass;
    logic [7:0]  e_disp      = 8'h00;
    logic [7:0]  e_miss      = 8'h00;
    logic [7:0]  e_ctrl      = 8'h00;
    logic        sync_n;
    logic        reinit;
    int          num_errors  = 0;
    int          num_checks  = 0;

    sem_monitor dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .link_enable(link_enable), .lane_k28_seen(k28),
        .lane_ilas_pass(pass), .lane_disp_err(e_disp), .lane_table_miss(e_miss),
        .lane_ctrl_err(e_ctrl), .sync_request_out_n(sync_n), .link_reinit(reinit));
    sem_tx_model tx (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .sync_request_out_n(sync_n), .lane_k28_seen(k28), .lane_ilas_pass(pass));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic stop_test;
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // errors held n back-to-back cycles; returns in the cycle after the last
    task automatic inj(input logic [7:0] d, m, c, input int n);
        @(posedge clk_sys);
        e_disp <= d;
        e_miss <= m;
        e_ctrl <= c;
        repeat (n) @(posedge clk_sys);
        e_disp <= 8'h00;
        e_miss <= 8'h00;
        e_ctrl <= 8'h00;
        #1;
    endtask : inj

    // sync held low for n samples, then level after
    task automatic low_for(input int n, input logic after);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            seen = seen | sync_n;
            @(posedge clk_sys);
            #1;
        end
        chk({6'h00, seen, sync_n}, {7'h00, after});
    endtask : low_for

    task automatic wait_high;
        int i;
        for (i = 0; i < 100 && sync_n !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h00, sync_n}, 8'h01);
    endtask : wait_high

    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    initial begin
        int i;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(SEM_ADDR_LIMIT, SEM_LIMIT_RST);
        rd(SEM_ADDR_PULSE, 8'h00);
        rd(12'h400, 8'h00);
        wr(SEM_ADDR_LIMIT, 8'h03);
        @(posedge clk_sys);
        link_enable <= 1'b1;
        wait_high();
        repeat (3) @(posedge clk_sys);
        rd(SEM_ADDR_ILAS_STAT, 8'hff);
        inj(8'h04, 8'h00, 8'h00, 1);
        low_for(1, 1'b1);
        wr(SEM_ADDR_ERR_SEL, 8'h20);
        rd(SEM_ADDR_ERR_SEL, 8'h01);
        inj(8'h00, 8'h02, 8'h00, 5);
        wr(SEM_ADDR_ERR_SEL, 8'h11);
        rd(SEM_ADDR_ERR_SEL, 8'h03);
        rd(SEM_ADDR_MISS, 8'h02);
        rd(SEM_ADDR_DISP, 8'h00);
        wr(SEM_ADDR_IRQ, 8'he0);
        rd(SEM_ADDR_IRQ, 8'h40);
        wr(SEM_ADDR_ERR_SEL, 8'h13);
        rd(SEM_ADDR_ERR_SEL, 8'h00);
        wr(SEM_ADDR_MISS, 8'h21);
        rd(SEM_ADDR_MISS, 8'h00);
        wr(SEM_ADDR_MISS, 8'h81);
        rd(SEM_ADDR_IRQ, 8'h00);
        wr(SEM_ADDR_MISS, 8'h41);
        inj(8'h00, 8'h02, 8'h00, 2);
        wr(SEM_ADDR_ERR_SEL, 8'h11);
        rd(SEM_ADDR_ERR_SEL, 8'h00);
        wr(SEM_ADDR_LINK_PAGE, 8'h04);
        inj(8'h00, 8'h00, 8'h20, 1);
        wr(SEM_ADDR_ERR_SEL, 8'h12);
        rd(SEM_ADDR_ERR_SEL, 8'h01);
        wr(SEM_ADDR_LINK_PAGE, 8'h00);
        rd(SEM_ADDR_ERR_SEL, 8'h00);
        wr(SEM_ADDR_PULSE, 8'h20);
        inj(8'h00, 8'h00, 8'h01, 3);
        low_for(2, 1'b1);
        rd(SEM_ADDR_IRQ, 8'h20);
        inj(8'h08, 8'h00, 8'h00, 4);
        for (i = 0; i < 5 && reinit !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h00, reinit}, 8'h01);
        low_for(14, 1'b0);
        wait_high();
        wr(SEM_ADDR_ERR_SEL, 8'h02);
        rd(SEM_ADDR_ERR_SEL, 8'h00);
        rd(SEM_ADDR_IRQ, 8'ha0);
        wr(SEM_ADDR_RESYNC, 8'h80);
        inj(8'h10, 8'h00, 8'h00, 3);
        for (i = 0; i < 5 && reinit !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk({7'h00, reinit}, 8'h01);
        wait_high();
        rd(SEM_ADDR_DISP, 8'h00);
        @(posedge clk_sys);
        link_enable <= 1'b0;
        wr(SEM_ADDR_TEST, 8'h88);
        @(posedge clk_sys);
        link_enable <= 1'b1;
        wait_high();
        inj(8'h00, 8'h00, 8'h01, 1);
        chk({7'h00, sync_n}, 8'h01);
        rd(SEM_ADDR_ERR_SEL, 8'h00);
        inj(8'h10, 8'h00, 8'h00, 5);
        wr(SEM_ADDR_ERR_SEL, 8'h40);
        rd(SEM_ADDR_ERR_SEL, 8'h05);
        stop_test();
    end
endmodule : sem_monitor_tb
